// file: logic/counter_cfg.svh
`ifndef COUNTER_CFG_SVH
`define COUNTER_CFG_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define REG_FUNC 8'h00
`define REG_EDGE 8'h04
`define REG_CYCLE_COUNT_SETTING 8'h08
`define REG_TBASE 8'h0c
`define REG_CMD 8'h10
`define REG_INTEN 8'h14
`define REG_STATUS 8'h18
`define REG_POLL 8'h1c
`define REG_VALUE 8'h20
`define REG_COUNT 8'h24
// ----------------------------------------
// field positions
// ----------------------------------------
`define EDGE_A_FALL 0
`define EDGE_B_FALL 1
`define EDGE_B_HIGH 2
`define EDGE_GATE 3
`define CMD_TRIG 0
`define CMD_CRST 1
`define IE_CH 0
`define IE_SYS 1
`define ST_PANEL 0
`define ST_LOCAL 1
`define ST_INTR 2
`define ST_LIMIT 3
`define ST_ALARM 4
// ----------------------------------------
// reset values and presets
// ----------------------------------------
`define EDGE_PRESET 4'h3
`define CYCLE_COUNT_SETTING_RST 16'h0001
`define MODE_MAX 3'h4
`define RTC_MASK 5'h1f
`define FLAGS_NONE 5'h00
`define WORD_ZERO 32'h0000_0000
`define HALF_ZERO 16'h0000
`define FRAC_PAD 16'h0000
`define TB_LIMIT 32'h0000_ffff
`define DIV_LAST 5'h1f
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 4
`define TBASE_RST_NS 1000
`define TBASE_RST_CYC (`TBASE_RST_NS / `CLK_PERIOD_NS)
`endif

// file: logic/counter_pkg.sv
package counter_pkg;
  // counting functions
  typedef enum logic [2:0] {
    count_direction_mode,
    count_direction_modulo_mode,
    quotient_mode,
    average_period_mode,
    delayed_interval_mode
  } mode_t;
  // measurement sequencer
  typedef enum logic [1:0] {st_idle, st_arm, st_run, st_div} meas_state_t;
endpackage : counter_pkg

// file: logic/div_seq.sv
`timescale 1ns/1ps
`include "counter_cfg.svh"
// restoring divider, one quotient bit per clock
module div_seq (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [31:0] dividend,
  input wire logic [15:0] divisor,
  output logic done,
  output logic [31:0] quotient
);
  logic busy_q, busy_d;
  logic done_q, done_d;
  logic [4:0] cnt_q, cnt_d; // step counter
  logic [15:0] rem_q, rem_d; // partial remainder
  logic [31:0] quo_q, quo_d; // shifting quotient
  logic [31:0] res_q, res_d; // held result
  logic [16:0] rem_sh;
  logic ge;
  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    busy_d = busy_q;
    done_d = 1'b0;
    cnt_d = cnt_q;
    rem_d = rem_q;
    quo_d = quo_q;
    res_d = res_q;
    rem_sh = {rem_q, quo_q[31]};
    ge = rem_sh >= {1'b0, divisor};
    if (start) begin // load operands
      busy_d = 1'b1;
      cnt_d = 5'h00;
      rem_d = `HALF_ZERO;
      quo_d = dividend;
    end else if (busy_q) begin // one step
      rem_d = ge ? 16'(rem_sh - {1'b0, divisor}) : rem_sh[15:0];
      quo_d = {quo_q[30:0], ge};
      cnt_d = 5'(cnt_q + 5'h01);
      if (cnt_q == `DIV_LAST) begin
        busy_d = 1'b0;
        done_d = 1'b1;
        res_d = {quo_q[30:0], ge};
      end
    end
  end
  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      cnt_q <= 5'h00;
      rem_q <= `HALF_ZERO;
      quo_q <= `WORD_ZERO;
      res_q <= `WORD_ZERO;
    end else begin
      busy_q <= busy_d;
      done_q <= done_d;
      cnt_q <= cnt_d;
      rem_q <= rem_d;
      quo_q <= quo_d;
      res_q <= res_d;
    end
  end
  assign done = done_q;
  assign quotient = res_q;
endmodule : div_seq

// file: logic/event_counter_channel.sv
`timescale 1ns/1ps
`include "counter_cfg.svh"
// Functional notes
// - count/direction: up while B at gate level
// - outside quadrature, only programmed A edge polarity changes count
// - quadrature counts every A edge, both polarities
// - quadrature: up if B leads, down otherwise
// - A dither with steady B nets zero
// - quadrature ignores edges; function select presets falling
// - quotient of A periods over N B periods
// - done event forwarded only with both enables
// - system enable needed besides channel enable
// - status read returns then clears five flags
// - poll read clears service request bit
// - average of N periods, N 1..65535
// - delayed mode times only the N-th period
// - average accumulates at most 65535 timebase ticks
// - delayed mode resolves finer, up to 65535 ticks
// - gated counting: A edges only at gate level
// - average mode ignores B input entirely
// - modulo mode wraps within programmable modulus
module event_counter_channel
  import counter_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic in_a,
  input wire logic in_b,
  input wire logic quad_sel,
  input wire logic panel_evt,
  input wire logic local_evt,
  input wire logic alarm_evt,
  output logic host_event
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic ack_q, ack_d; // bus answer strobe
  logic [31:0] rdata_q, rdata_d; // registered read data
  mode_t mode_q, mode_d; // selected function
  logic [3:0] edge_q, edge_d; // edge and gate selection
  logic [15:0] cycle_count_setting_q, cycle_count_setting_d; // cycle_count_setting
  logic [31:0] tbase_q, tbase_d; // clocks per timebase tick
  logic [1:0] ie_q, ie_d; // channel and system enables
  logic [4:0] flags_q, flags_d; // sticky status flags
  logic srq_q, srq_d; // service request
  logic evt_q, evt_d; // forwarded event
  meas_state_t st_q, st_d; // sequencer
  logic [31:0] count_q, count_d; // event accumulator
  logic [15:0] pcnt_q, pcnt_d; // periods seen
  logic [31:0] time_q, time_d; // timebase ticks
  logic [31:0] fine_q, fine_d; // clock cycles in period
  logic [31:0] tbc_q, tbc_d; // timebase divider
  logic [31:0] res_q, res_d; // measurement result
  logic wr_go, rd_go, trig_cmd, crst_cmd;
  logic [2:0] lvl, rise, fall;
  logic a_sel, b_sel, gate_ok, quad, cnt_en, up, tick;
  logic done_evt, limit_evt, div_start, div_done;
  logic [31:0] div_num, div_quo;
  logic [4:0] set_v, clr_v;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // up/down step with optional wrap within modulus
  function automatic logic [31:0] step(input logic [31:0] c, input logic u,
                                       input logic modw, input logic [15:0] m);
    logic [31:0] top;
    top = {`HALF_ZERO, m} - 32'h1;
    if (modw && u) step = (c >= top) ? `WORD_ZERO : c + 32'h1;
    else if (modw) step = (c == `WORD_ZERO) ? top : c - 32'h1;
    else step = u ? c + 32'h1 : c - 32'h1;
  endfunction : step

  // saturating tick add, reports overflow
  function automatic logic [32:0] sat_inc(input logic [31:0] v, input logic lim_on);
    if (lim_on && v >= `TB_LIMIT) sat_inc = {1'b1, `TB_LIMIT};
    else sat_inc = {1'b0, v + 32'h1};
  endfunction : sat_inc

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  input_sync u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .raw({quad_sel, in_b, in_a}),
    .lvl(lvl),
    .rise(rise),
    .fall(fall)
  );

  // ----------------------------------------
  // divider for quotient and average
  // ----------------------------------------
  div_seq u_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(div_start),
    .dividend(div_num),
    .divisor(cycle_count_setting_q),
    .done(div_done),
    .quotient(div_quo)
  );

  // ----------------------------------------
  // bus strobes
  // ----------------------------------------
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign wr_go = avs_write & ack_q;
  assign rd_go = avs_read & ack_q;
  assign trig_cmd = wr_go && avs_address == `REG_CMD && avs_writedata[`CMD_TRIG];
  assign crst_cmd = wr_go && avs_address == `REG_CMD && avs_writedata[`CMD_CRST];
  assign avs_readdata = rdata_q;
  assign host_event = evt_q;

  // edge picks and gate
  assign a_sel = edge_q[`EDGE_A_FALL] ? fall[0] : rise[0];
  assign b_sel = edge_q[`EDGE_B_FALL] ? fall[1] : rise[1];
  assign gate_ok = ~edge_q[`EDGE_GATE] | (lvl[1] == edge_q[`EDGE_B_HIGH]);
  assign quad = lvl[2];
  assign cnt_en = quad ? (rise[0] | fall[0]) : a_sel;
  assign up = quad ? ((rise[0] & lvl[1]) | (fall[0] & ~lvl[1]))
                   : (lvl[1] == edge_q[`EDGE_B_HIGH]);

  // timebase tick
  assign tick = tbc_q >= tbase_q - 32'h1;

  // ----------------------------------------
  // register file next values
  // ----------------------------------------
  always_comb begin
    ack_d = (avs_read | avs_write) & ~ack_q;
    rdata_d = rdata_q;
    mode_d = mode_q;
    edge_d = edge_q;
    cycle_count_setting_d = cycle_count_setting_q;
    tbase_d = tbase_q;
    ie_d = ie_q;
    set_v = `FLAGS_NONE;
    clr_v = `FLAGS_NONE;
    // read mux, captured before the answer cycle
    if (avs_read && !ack_q) begin
      if (avs_address == `REG_FUNC) rdata_d = {29'h0, mode_q};
      else if (avs_address == `REG_EDGE) rdata_d = {28'h0, edge_q};
      else if (avs_address == `REG_CYCLE_COUNT_SETTING) rdata_d = {`HALF_ZERO, cycle_count_setting_q};
      else if (avs_address == `REG_TBASE) rdata_d = tbase_q;
      else if (avs_address == `REG_INTEN) rdata_d = {30'h0, ie_q};
      else if (avs_address == `REG_STATUS || avs_address == `REG_POLL)
        rdata_d = {25'h0, st_q != st_idle, srq_q, flags_q};
      else if (avs_address == `REG_VALUE) rdata_d = res_q;
      else if (avs_address == `REG_COUNT) rdata_d = count_q;
      else rdata_d = `WORD_ZERO; // unmapped
    end
    // writes
    if (wr_go) begin
      if (avs_address == `REG_FUNC && avs_writedata[2:0] <= `MODE_MAX) begin
        mode_d = mode_t'(avs_writedata[2:0]);
        edge_d = `EDGE_PRESET;
      end else if (avs_address == `REG_EDGE) edge_d = avs_writedata[3:0];
      else if (avs_address == `REG_CYCLE_COUNT_SETTING && avs_writedata[15:0] != `HALF_ZERO)
        cycle_count_setting_d = avs_writedata[15:0];
      else if (avs_address == `REG_TBASE && avs_writedata != `WORD_ZERO)
        tbase_d = avs_writedata;
      else if (avs_address == `REG_INTEN) ie_d = avs_writedata[1:0];
    end
    if (crst_cmd) begin
      edge_d = `EDGE_PRESET;
      cycle_count_setting_d = `CYCLE_COUNT_SETTING_RST;
    end
    // sticky flags, set wins over clear
    set_v[`ST_PANEL] = panel_evt;
    set_v[`ST_LOCAL] = local_evt;
    set_v[`ST_INTR] = done_evt;
    set_v[`ST_LIMIT] = limit_evt;
    set_v[`ST_ALARM] = alarm_evt;
    if (rd_go && avs_address == `REG_STATUS) clr_v = `RTC_MASK;
    if (crst_cmd) clr_v[`ST_INTR] = 1'b1;
    flags_d = (flags_q & ~clr_v) | set_v;
    // service request and forwarded event need both enables
    srq_d = srq_q;
    if ((rd_go && avs_address == `REG_POLL) || crst_cmd) srq_d = 1'b0;
    evt_d = done_evt & ie_q[`IE_CH] & ie_q[`IE_SYS];
    if (evt_d) srq_d = 1'b1;
  end

  // ----------------------------------------
  // register file flops
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdata_q <= `WORD_ZERO;
      mode_q <= count_direction_mode;
      edge_q <= `EDGE_PRESET;
      cycle_count_setting_q <= `CYCLE_COUNT_SETTING_RST;
      tbase_q <= 32'(`TBASE_RST_CYC);
      ie_q <= 2'h0;
      flags_q <= `FLAGS_NONE;
      srq_q <= 1'b0;
      evt_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      mode_q <= mode_d;
      edge_q <= edge_d;
      cycle_count_setting_q <= cycle_count_setting_d;
      tbase_q <= tbase_d;
      ie_q <= ie_d;
      flags_q <= flags_d;
      srq_q <= srq_d;
      evt_q <= evt_d;
    end
  end

  // ----------------------------------------
  // measurement next values
  // ----------------------------------------
  always_comb begin
    logic [32:0] t_inc;
    t_inc = sat_inc(time_q, 1'b1);
    st_d = st_q;
    count_d = count_q;
    pcnt_d = pcnt_q;
    time_d = time_q;
    fine_d = fine_q;
    tbc_d = tick ? `WORD_ZERO : tbc_q + 32'h1;
    res_d = res_q;
    done_evt = 1'b0;
    limit_evt = 1'b0;
    div_start = 1'b0;
    div_num = `WORD_ZERO;
    case (st_q)
      st_idle: begin
        // hold accumulators until triggered
      end
      st_arm: begin
        // wait for the opening edge
        if (mode_q == quotient_mode && b_sel) st_d = st_run;
        if (mode_q == average_period_mode && a_sel) st_d = st_run;
        if (mode_q == delayed_interval_mode && a_sel && gate_ok) st_d = st_run;
      end
      st_run: begin
        case (mode_q)
          count_direction_mode, count_direction_modulo_mode: begin
            if (cnt_en) count_d = step(count_q, up,
                                       mode_q == count_direction_modulo_mode, cycle_count_setting_q);
          end
          quotient_mode: begin
            if (a_sel && gate_ok) count_d = count_q + 32'h1;
            if (a_sel && count_q >= `TB_LIMIT) limit_evt = 1'b1;
            if (b_sel) begin
              pcnt_d = 16'(pcnt_q + 16'h1);
              if (16'(pcnt_q + 16'h1) == cycle_count_setting_q) begin
                div_start = 1'b1;
                div_num = {count_d[15:0], `FRAC_PAD};
                st_d = st_div;
              end
            end
          end
          average_period_mode: begin
            if (tick) begin
              time_d = t_inc[31:0];
              limit_evt = t_inc[32];
            end
            if (a_sel) begin
              pcnt_d = 16'(pcnt_q + 16'h1);
              if (16'(pcnt_q + 16'h1) == cycle_count_setting_q) begin
                div_start = 1'b1;
                div_num = {time_d[15:0], `FRAC_PAD};
                st_d = st_div;
              end
            end
          end
          default: begin // delayed interval
            if (pcnt_q == 16'(cycle_count_setting_q - 16'h1)) begin
              fine_d = fine_q + 32'h1;
              if (tick) begin
                time_d = t_inc[31:0];
                limit_evt = t_inc[32];
              end
            end
            if (a_sel && gate_ok) begin
              pcnt_d = 16'(pcnt_q + 16'h1);
              if (pcnt_q == 16'(cycle_count_setting_q - 16'h1)) begin
                res_d = fine_d; // closing cycle belongs to the period
                done_evt = 1'b1;
                st_d = st_idle;
              end
            end
          end
        endcase
      end
      default: begin // st_div
        if (div_done) begin
          res_d = div_quo;
          done_evt = 1'b1;
          st_d = st_idle;
        end
      end
    endcase
    // trigger restarts; reset clears
    if (trig_cmd || crst_cmd) begin
      count_d = `WORD_ZERO;
      pcnt_d = `HALF_ZERO;
      time_d = `WORD_ZERO;
      fine_d = `WORD_ZERO;
      tbc_d = `WORD_ZERO;
      done_evt = 1'b0;
      limit_evt = 1'b0;
      div_start = 1'b0;
      if (crst_cmd) begin
        st_d = st_idle;
        res_d = `WORD_ZERO;
      end else if (mode_q == count_direction_mode || mode_q == count_direction_modulo_mode)
        st_d = st_run;
      else st_d = st_arm;
    end
  end

  // ----------------------------------------
  // measurement flops
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= st_idle;
      count_q <= `WORD_ZERO;
      pcnt_q <= `HALF_ZERO;
      time_q <= `WORD_ZERO;
      fine_q <= `WORD_ZERO;
      tbc_q <= `WORD_ZERO;
      res_q <= `WORD_ZERO;
    end else begin
      st_q <= st_d;
      count_q <= count_d;
      pcnt_q <= pcnt_d;
      time_q <= time_d;
      fine_q <= fine_d;
      tbc_q <= tbc_d;
      res_q <= res_d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  cd_up_b_a: assert property (@(posedge ref_clk) disable iff (rst)
    st_q == st_run && mode_q == count_direction_mode && !quad && a_sel
    && lvl[1] == edge_q[`EDGE_B_HIGH] && !trig_cmd && !crst_cmd
    |=> count_q == $past(count_q) + 32'h1) else $error("cd up count missed");
  cd_opp_edge_a: assert property (@(posedge ref_clk) disable iff (rst)
    st_q == st_run && mode_q == count_direction_mode && !quad && !a_sel
    && !trig_cmd && !crst_cmd |=> $stable(count_q)) else $error("count moved off edge");
  quad_dir_a: assert property (@(posedge ref_clk) disable iff (rst)
    st_q == st_run && mode_q == count_direction_mode && quad && fall[0] && !lvl[1]
    && !trig_cmd && !crst_cmd |=> count_q == $past(count_q) + 32'h1)
    else $error("quadrature direction wrong");
  func_preset_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_go && avs_address == `REG_FUNC && avs_writedata[2:0] <= `MODE_MAX
    |=> edge_q == `EDGE_PRESET && mode_q == mode_t'($past(avs_writedata[2:0])))
    else $error("function preset not applied");
  evt_enable_a: assert property (@(posedge ref_clk) disable iff (rst)
    host_event |-> $past(ie_q) == 2'h3 && $past(done_evt)) else $error("event not gated");
  stat_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd_go && avs_address == `REG_STATUS
    |=> (flags_q & ~$past(set_v)) == `FLAGS_NONE) else $error("status not cleared");
  poll_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd_go && avs_address == `REG_POLL && !evt_d |=> !srq_q) else $error("srq not cleared");
  tick_limit_a: assert property (@(posedge ref_clk) disable iff (rst)
    time_q <= `TB_LIMIT) else $error("tick accumulator over limit");
  idle_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    st_q == st_idle && !trig_cmd && !crst_cmd |=> $stable(count_q) && st_q == st_idle)
    else $error("idle accumulator moved");
  chan_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
    crst_cmd |=> count_q == `WORD_ZERO && !flags_q[`ST_INTR] && cycle_count_setting_q == `CYCLE_COUNT_SETTING_RST
    && st_q == st_idle) else $error("channel reset incomplete");
  mod_wrap_a: assert property (@(posedge ref_clk) disable iff (rst)
    st_q == st_run && mode_q == count_direction_modulo_mode && cnt_en && up
    && count_q == {`HALF_ZERO, cycle_count_setting_q} - 32'h1 && !trig_cmd && !crst_cmd
    |=> count_q == `WORD_ZERO) else $error("modulo wrap missed");
endmodule : event_counter_channel

// file: logic/input_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser plus edge detect on the second stage
module input_sync (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [2:0] raw,
  output logic [2:0] lvl,
  output logic [2:0] rise,
  output logic [2:0] fall
);
  logic [2:0] s1_q, s2_q, s3_q; // sync stages and edge history
  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign lvl = s2_q;
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;
endmodule : input_sync

// file: verif/encoder_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// shaft encoder and pulse sources on a and b
// ----------------------------------------
module encoder_model (
  input wire logic clk,
  output logic a,
  output logic b
);
  // both lines idle low
  initial begin
    a = 1'b0;
    b = 1'b0;
  end
  // set both lines after an edge, hold for n cycles
  task automatic ab(input logic va, input logic vb, input int n);
    @(posedge clk);
    a <= va;
    b <= vb;
    repeat (n - 1) @(posedge clk);
  endtask : ab
  // b leads a by a quarter cycle
  task automatic cw(input int n);
    repeat (n) begin
      ab(1'b0, 1'b1, 8);
      ab(1'b1, 1'b1, 8);
      ab(1'b1, 1'b0, 8);
      ab(1'b0, 1'b0, 8);
    end
  endtask : cw
  // a leads b by a quarter cycle
  task automatic ccw(input int n);
    repeat (n) begin
      ab(1'b1, 1'b0, 8);
      ab(1'b1, 1'b1, 8);
      ab(1'b0, 1'b1, 8);
      ab(1'b0, 1'b0, 8);
    end
  endtask : ccw
endmodule : encoder_model

// file: verif/event_counter_channel_tb.sv
`timescale 1ns/1ps
`include "counter_cfg.svh"
module event_counter_channel_tb;
  import counter_pkg::*;
  // ----------------------------------------
  // stimulus and bookkeeping
  // ----------------------------------------
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic in_a;
  logic in_b;
  logic quad_sel = 1'b0;
  logic panel_evt = 1'b0;
  logic local_evt = 1'b0;
  logic alarm_evt = 1'b0;
  logic host_event;
  int failures = 0;
  int cmp_count = 0;
  int evt_cnt = 0;
  logic [31:0] r;
  always #2 ref_clk = ~ref_clk;
  // count forwarded completion pulses
  always @(posedge ref_clk) if (host_event === 1'b1) evt_cnt++;
  event_counter_channel dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .in_a(in_a),
    .in_b(in_b), .quad_sel(quad_sel), .panel_evt(panel_evt), .local_evt(local_evt),
    .alarm_evt(alarm_evt), .host_event(host_event));
  encoder_model enc (.clk(ref_clk), .a(in_a), .b(in_b));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    avs_address <= ad;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= wd;
    n = 0;
    // waitrequest and readdata are read as they stood at this rising edge
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    if (n >= 50) begin
      failures++;
      final_report();
    end
    // release at the accepting edge, then let one edge pass
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, ad, d, x);
  endtask : wr
  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    bus(1'b0, ad, 32'h0000_0000, d);
  endtask : rd
  // poll status until the done flag has been seen
  task automatic wait_done();
    logic [31:0] acc;
    int n;
    acc = 32'h0000_0000;
    n = 0;
    do begin
      rd(`REG_STATUS, r);
      acc = acc | r;
      n++;
    end while (acc[`ST_INTR] !== 1'b1 && n < 100);
    if (n >= 100) begin
      failures++;
      final_report();
    end
  endtask : wait_done
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_flags();
    rd(`REG_EDGE, r);
    check("edge reset", r, 32'h0000_0003);
    rd(8'h3c, r);
    check("unmapped read", r, 32'h0000_0000);
    panel_evt <= 1'b1;
    local_evt <= 1'b1;
    alarm_evt <= 1'b1;
    @(posedge ref_clk);
    panel_evt <= 1'b0;
    local_evt <= 1'b0;
    alarm_evt <= 1'b0;
    rd(`REG_STATUS, r);
    check("flags set", r & 32'h1f, 32'h0000_0013);
    rd(`REG_STATUS, r);
    check("flags cleared", r & 32'h1f, 32'h0000_0000);
  endtask : t_flags
  task automatic t_cd();
    wr(`REG_EDGE, 32'h0000_0004);
    repeat (2) enc.ab(1'b1, 1'b1, 8);
    enc.ab(1'b0, 1'b1, 8);
    rd(`REG_COUNT, r);
    check("idle before trigger", r, 32'h0000_0000);
    wr(`REG_CMD, 32'h0000_0001);
    repeat (3) begin
      enc.ab(1'b1, 1'b1, 8);
      enc.ab(1'b0, 1'b1, 8);
    end
    enc.ab(1'b0, 1'b0, 8);
    enc.ab(1'b1, 1'b0, 8);
    enc.ab(1'b0, 1'b0, 8);
    rd(`REG_COUNT, r);
    check("cd net count", r, 32'h0000_0002);
    wr(`REG_CMD, 32'h0000_0002);
    rd(`REG_COUNT, r);
    check("count after reset", r, 32'h0000_0000);
    rd(`REG_EDGE, r);
    check("edge preset", r, 32'h0000_0003);
  endtask : t_cd
  task automatic t_quad();
    quad_sel <= 1'b1;
    wr(`REG_FUNC, 32'(count_direction_mode));
    rd(`REG_EDGE, r);
    check("quad edge preset", r, 32'h0000_0003);
    wr(`REG_EDGE, 32'h0000_0004);
    wr(`REG_CMD, 32'h0000_0001);
    enc.cw(3);
    rd(`REG_COUNT, r);
    check("quad cw", r, 32'h0000_0006);
    repeat (4) begin
      enc.ab(1'b1, 1'b0, 8);
      enc.ab(1'b0, 1'b0, 8);
    end
    rd(`REG_COUNT, r);
    check("quad dither", r, 32'h0000_0006);
    enc.ccw(1);
    rd(`REG_COUNT, r);
    check("quad ccw", r, 32'h0000_0004);
    quad_sel <= 1'b0;
  endtask : t_quad
  task automatic t_mod();
    wr(`REG_FUNC, 32'(count_direction_modulo_mode));
    wr(`REG_EDGE, 32'h0000_0004);
    wr(`REG_CYCLE_COUNT_SETTING, 32'h0000_0005);
    wr(`REG_CMD, 32'h0000_0001);
    repeat (7) begin
      enc.ab(1'b1, 1'b1, 8);
      enc.ab(1'b0, 1'b1, 8);
    end
    rd(`REG_COUNT, r);
    check("modulo wrap", r, 32'h0000_0002);
  endtask : t_mod
  task automatic t_ratio(input logic [31:0] ie, input int ev);
    int e0;
    e0 = evt_cnt;
    wr(`REG_FUNC, 32'(quotient_mode));
    wr(`REG_EDGE, 32'h0000_0000);
    wr(`REG_CYCLE_COUNT_SETTING, 32'h0000_0002);
    wr(`REG_INTEN, ie);
    wr(`REG_CMD, 32'h0000_0001);
    enc.ab(1'b0, 1'b0, 8);
    enc.ab(1'b0, 1'b1, 8); // opening b edge
    repeat (2) begin
      repeat (3) begin
        enc.ab(1'b1, 1'b1, 6);
        enc.ab(1'b0, 1'b1, 6);
      end
      enc.ab(1'b0, 1'b0, 8);
      enc.ab(1'b0, 1'b1, 8);
    end
    wait_done();
    rd(`REG_VALUE, r);
    check("quotient", r, 32'h0003_0000);
    check("event forward", 32'(evt_cnt - e0), 32'(ev));
    rd(`REG_POLL, r);
    check("srq set", 32'(r[5]), 32'(ev));
    rd(`REG_POLL, r);
    check("srq cleared", 32'(r[5]), 32'h0000_0000);
  endtask : t_ratio
  task automatic t_avg();
    wr(`REG_FUNC, 32'(average_period_mode));
    wr(`REG_EDGE, 32'h0000_0000);
    wr(`REG_TBASE, 32'h0000_0004);
    wr(`REG_CMD, 32'h0000_0001);
    for (int i = 0; i < 3; i++) begin
      enc.ab(1'b1, i[0], 4);
      enc.ab(1'b0, i[0], 36);
    end
    wait_done();
    rd(`REG_VALUE, r);
    check("average period", r, 32'h000a_0000);
  endtask : t_avg
  task automatic t_delay();
    wr(`REG_FUNC, 32'(delayed_interval_mode));
    wr(`REG_EDGE, 32'h0000_0008);
    wr(`REG_CMD, 32'h0000_0001);
    enc.ab(1'b1, 1'b0, 4);
    enc.ab(1'b0, 1'b0, 16);
    enc.ab(1'b1, 1'b0, 4);
    enc.ab(1'b0, 1'b0, 4);
    enc.ab(1'b0, 1'b1, 4);
    enc.ab(1'b1, 1'b1, 4);
    enc.ab(1'b0, 1'b1, 4);
    enc.ab(1'b0, 1'b0, 16);
    enc.ab(1'b1, 1'b0, 4);
    enc.ab(1'b0, 1'b0, 4);
    wait_done();
    rd(`REG_VALUE, r);
    check("nth gated period", r, 32'h0000_0024);
  endtask : t_delay
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_flags();
    t_cd();
    t_quad();
    t_mod();
    t_ratio(32'h0000_0001, 0);
    t_ratio(32'h0000_0003, 1);
    t_avg();
    t_delay();
    final_report();
  end
endmodule : event_counter_channel_tb
